// ===== hw/eeh_host.sv
// Functional notes
// - select low at least 1 us between
// - each bit clocked by high then low
// - clock high 1 us, low 3 us
// - start bit then two-bit opcode encoding
// - select first, header msb first, read 110b
// - address msb first, sample after pulse
// - probe counts address bits until zero
// - probe ends with 16 discarded bits
// - read 16 bits, sample while clock high
// - write 16 bits msb first
// - every access ends with select low
// - address width known before access
// - no other bus traffic meanwhile
// - width 6 or 8 bits
// - eeprom drives dummy zero after address
`timescale 1ns/1ps
module eeh_host #(
    parameter int CLK_PERIOD_PS = eeh_pkg::CLK_PERIOD_PS,
    parameter logic [3:0] ADDR_W_RESET = eeh_pkg::ADDR_W_RST
) (
    input wire logic CLK_SYS,
    input wire logic RSTN,
    input wire logic [7:0] SW_ADDR,
    input wire logic [31:0] SW_WDATA,
    input wire logic SW_WR,
    input wire logic SW_RD,
    output logic [31:0] SW_RDATA,
    output logic [7:0] DEV_ADDR,
    output logic [31:0] DEV_WDATA,
    output logic [3:0] DEV_BE,
    output logic DEV_WR,
    output logic DEV_RD,
    input wire logic [31:0] DEV_RDATA
);
    import eeh_pkg::*;
    localparam int TICK_CYC = (US_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // phase minimums follow the divider actually built, not the package clock
    localparam int HI_CYC = int'(SK_HIGH_US) * TICK_CYC;
    localparam int LO_CYC = int'(SK_LOW_US) * TICK_CYC;
    localparam int GAP_CYC = int'(CS_GAP_US) * TICK_CYC;

    // the phase checkers count in twelve bits and saturate just below the top
    if (LO_CYC > 4000) begin : g_bad_clock
        $error("system clock too fast for the phase checkers");
    end

    if (ADDR_W_RESET < 4'h2 || ADDR_W_RESET > ADDR_W_MAX) begin : g_bad_width
        $error("address width reset value out of range");
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [1:0] op_code(input eeh_op_type op);
        unique case (op)
            READ_CMD, SIZE_PROBE_CMD: return OPC_READ;
            WRITE_CMD: return OPC_WRITE;
            ERASE_CMD: return OPC_ERASE;
            default: return OPC_SPECIAL;
        endcase
    endfunction

    // special commands carry their sub-code in the two leading address bits
    function automatic logic [7:0] addr_field(input eeh_op_type op, input logic [7:0] a,
                                              input logic [3:0] w);
        logic [1:0] sub;
        sub = SUB_DISABLE;
        unique case (op)
            ERASE_WRITE_ENABLE_CMD: sub = SUB_ENABLE;
            ERASE_ALL_CMD: sub = SUB_ERASE_ALL;
            WRITE_ALL_CMD: sub = SUB_WRITE_ALL;
            default: sub = SUB_DISABLE;
        endcase
        if (op_code(op) != OPC_SPECIAL) return a;
        return 8'({sub, 6'h00} >> (ADDR_W_BIG - w));
    endfunction

    function automatic logic [31:0] port_word(input logic cs, input logic di, input logic sk);
        logic [31:0] v;
        v = 32'h0000_0000;
        v[CS_POS] = cs;
        v[DI_POS] = di;
        v[SK_POS] = sk;
        return v;
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    eeh_state_type st_q, st_d, ret_q, ret_d;
    eeh_phase_type phase_q, phase_d;
    eeh_op_type op_q;
    logic [3:0] idx_q, idx_d, aw_q;
    logic [1:0] wait_q, wait_d;
    logic [7:0] addr_q;
    logic [15:0] wdata_q, rx_q, rx_d, rdata_q;
    logic busy_q, done_q, nodummy_q, dummy_q, dummy_d;
    logic cs_q, di_q, sk_q, cs_d, di_d, sk_d, wr_d, rd_d;
    logic aw_upd, no_dummy_end;

    eeh_tick_if tk();
    eeh_tick #(.US_CYCLES(TICK_CYC)) u_tick (.clk(CLK_SYS), .rstn(RSTN), .tk(tk.gen));

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire do_in = DEV_RDATA[DO_POS];
    wire sw_wr_idle = SW_WR && !busy_q;
    wire launch = sw_wr_idle && SW_ADDR == SW_CTRL_OFS && SW_WDATA[CTRL_GO_POS];
    wire is_probe = (op_q == SIZE_PROBE_CMD);
    wire reads_data = (op_q == READ_CMD) || is_probe;
    wire has_data = reads_data || op_q == WRITE_CMD || op_q == WRITE_ALL_CMD;
    wire [2:0] hdr_bits = {1'b1, op_code(op_q)};
    wire [7:0] addr_eff = addr_field(op_q, addr_q, aw_q);
    wire [2:0] addr_pos = 3'(aw_q - 4'h1 - idx_q);
    wire hdr_bit = hdr_bits[2'(2'h2 - idx_q[1:0])];
    wire addr_bit = !is_probe && addr_eff[addr_pos];
    wire data_bit = !reads_data && wdata_q[4'(4'hF - idx_q)];
    wire out_bit = (phase_q == PH_HDR) ? hdr_bit :
                   (phase_q == PH_ADDR) ? addr_bit : data_bit;
    wire addr_last = is_probe ? (dummy_q || idx_q == ADDR_W_MAX - 4'h1)
                              : (idx_q == aw_q - 4'h1);
    wire fin = (st_q == ST_WAIT) && (ret_q == ST_IDLE) && tk.tick && wait_q == 2'h1;
    assign tk.clr = (st_q == ST_HI) || (st_q == ST_LO) || (st_q == ST_DESEL);

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        ret_d = ret_q;
        phase_d = phase_q;
        idx_d = idx_q;
        wait_d = wait_q;
        dummy_d = dummy_q;
        rx_d = rx_q;
        cs_d = cs_q;
        di_d = di_q;
        sk_d = sk_q;
        wr_d = 1'b0;
        rd_d = 1'b0;
        aw_upd = 1'b0;
        no_dummy_end = 1'b0;
        unique case (st_q)
            ST_IDLE: if (launch) begin
                st_d = ST_SEL;
                phase_d = PH_HDR;
                idx_d = 4'h0;
                dummy_d = 1'b0;
            end
            ST_SEL: begin
                wr_d = 1'b1;
                cs_d = 1'b1;
                di_d = 1'b0;
                sk_d = 1'b0;
                st_d = ST_SET;
            end
            ST_SET: begin
                wr_d = 1'b1;
                di_d = out_bit;
                st_d = ST_HI;
            end
            ST_HI: begin
                wr_d = 1'b1;
                sk_d = 1'b1;
                wait_d = SK_HIGH_US;
                st_d = ST_WAIT;
                ret_d = (phase_q == PH_DATA && reads_data) ? ST_RREQ : ST_LO;
            end
            ST_LO: begin
                wr_d = 1'b1;
                sk_d = 1'b0;
                wait_d = SK_LOW_US;
                st_d = ST_WAIT;
                ret_d = (phase_q == PH_ADDR) ? ST_RREQ : ST_ADV;
            end
            ST_WAIT: if (tk.tick) begin
                wait_d = 2'(wait_q - 2'h1);
                if (wait_q == 2'h1) st_d = ret_q;
            end
            ST_RREQ: begin
                rd_d = 1'b1;
                st_d = ST_RWAIT;
            end
            ST_RWAIT: st_d = ST_RTAKE;
            ST_RTAKE: begin
                if (phase_q == PH_DATA) begin
                    rx_d = {rx_q[14:0], do_in};
                    st_d = ST_LO;
                end else begin
                    if (!do_in) dummy_d = 1'b1;
                    st_d = ST_ADV;
                end
            end
            ST_ADV: begin
                st_d = ST_SET;
                idx_d = 4'(idx_q + 4'h1);
                unique case (phase_q)
                    PH_HDR: if (idx_q == HDR_BITS - 4'h1) begin
                        phase_d = PH_ADDR;
                        idx_d = 4'h0;
                    end
                    PH_ADDR: if (addr_last) begin
                        aw_upd = is_probe;
                        no_dummy_end = !dummy_q;
                        phase_d = PH_DATA;
                        idx_d = 4'h0;
                        if (!has_data) st_d = ST_DESEL;
                    end
                    PH_DATA: if (idx_q == 4'(DATA_BITS - 5'h01)) st_d = ST_DESEL;
                    default: st_d = ST_DESEL;
                endcase
            end
            ST_DESEL: begin
                wr_d = 1'b1;
                cs_d = 1'b0;
                di_d = 1'b0;
                sk_d = 1'b0;
                wait_d = CS_GAP_US;
                st_d = ST_WAIT;
                ret_d = ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // flops
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            st_q <= ST_IDLE;
            ret_q <= ST_IDLE;
            phase_q <= PH_HDR;
            idx_q <= 4'h0;
            wait_q <= 2'h0;
            dummy_q <= 1'b0;
            rx_q <= 16'h0000;
            cs_q <= 1'b0;
            di_q <= 1'b0;
            sk_q <= 1'b0;
        end else begin
            st_q <= st_d;
            ret_q <= ret_d;
            phase_q <= phase_d;
            idx_q <= idx_d;
            wait_q <= wait_d;
            dummy_q <= dummy_d;
            rx_q <= rx_d;
            cs_q <= cs_d;
            di_q <= di_d;
            sk_q <= sk_d;
        end
    end

    // one fixed byte lane keeps the other control bytes untouched
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            DEV_ADDR <= DEV_CTRL_OFS;
            DEV_BE <= DEV_PORT_BE;
            DEV_WDATA <= 32'h0000_0000;
            DEV_WR <= 1'b0;
            DEV_RD <= 1'b0;
        end else begin
            DEV_WR <= wr_d;
            DEV_RD <= rd_d;
            if (wr_d) DEV_WDATA <= port_word(cs_d, di_d, sk_d);
        end
    end

    // ------------------------------------------------------------
    // own registers
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            op_q <= READ_CMD;
            addr_q <= 8'h00;
            wdata_q <= 16'h0000;
            aw_q <= ADDR_W_RESET;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            nodummy_q <= 1'b0;
            rdata_q <= 16'h0000;
        end else begin
            if (launch) op_q <= eeh_op_type'(SW_WDATA[CTRL_OP_LSB +: 3]);
            if (sw_wr_idle && SW_ADDR == SW_ADDR_OFS) addr_q <= SW_WDATA[7:0];
            if (sw_wr_idle && SW_ADDR == SW_WDATA_OFS) wdata_q <= SW_WDATA[15:0];
            if (aw_upd) aw_q <= 4'(idx_q + 4'h1);
            else if (sw_wr_idle && SW_ADDR == SW_CFG_OFS) aw_q <= SW_WDATA[3:0];
            busy_q <= launch || (busy_q && !fin);
            done_q <= fin || (done_q && !launch);
            nodummy_q <= no_dummy_end || (nodummy_q && !launch);
            if (fin && op_q == READ_CMD) rdata_q <= rx_q;
        end
    end

    wire [31:0] stat_word = {20'h00000, aw_q, 5'h00, nodummy_q, done_q, busy_q};
    wire [31:0] rd_mux =
        (SW_ADDR == SW_CTRL_OFS) ? {28'h0000000, op_q, 1'b0} :
        (SW_ADDR == SW_ADDR_OFS) ? {24'h000000, addr_q} :
        (SW_ADDR == SW_WDATA_OFS) ? {16'h0000, wdata_q} :
        (SW_ADDR == SW_STAT_OFS) ? stat_word :
        (SW_ADDR == SW_RDATA_OFS) ? {16'h0000, rdata_q} :
        (SW_ADDR == SW_CFG_OFS) ? {28'h0000000, aw_q} : 32'h0000_0000;

    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) SW_RDATA <= 32'h0000_0000;
        else if (SW_RD) SW_RDATA <= rd_mux;
        else SW_RDATA <= 32'h0000_0000;
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic [11:0] hi_cyc_q, lo_cyc_q, cs_cyc_q;
    logic [5:0] rise_q;
    wire sk_rise = DEV_WR && DEV_WDATA[SK_POS];
    wire sk_fall = DEV_WR && !DEV_WDATA[SK_POS] && hi_cyc_q != 12'hFFF;
    wire cs_rise = DEV_WR && DEV_WDATA[CS_POS] && cs_cyc_q != 12'hFFE;
    wire cs_fall = DEV_WR && !DEV_WDATA[CS_POS];

    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            hi_cyc_q <= 12'hFFF;
            lo_cyc_q <= 12'hFFE;
            cs_cyc_q <= 12'hFFD;
            rise_q <= 6'h00;
        end else begin
            hi_cyc_q <= sk_rise ? 12'h000 : sk_fall ? 12'hFFF :
                        (hi_cyc_q < 12'hFFD) ? 12'(hi_cyc_q + 12'h001) : hi_cyc_q;
            lo_cyc_q <= sk_fall ? 12'h000 :
                        (lo_cyc_q < 12'hFFE) ? 12'(lo_cyc_q + 12'h001) : lo_cyc_q;
            cs_cyc_q <= cs_fall ? 12'h000 : cs_rise ? 12'hFFE :
                        (cs_cyc_q < 12'hFFD) ? 12'(cs_cyc_q + 12'h001) : cs_cyc_q;
            rise_q <= launch ? 6'h00 : (sk_rise ? 6'(rise_q + 6'h01) : rise_q);
        end
    end

    sk_high_time_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        sk_fall |-> hi_cyc_q >= 12'(HI_CYC)) else $error("clock high phase too short");
    sk_low_time_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        sk_rise |-> lo_cyc_q >= 12'(LO_CYC)) else $error("clock low phase too short");
    cs_gap_time_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        cs_rise |-> cs_cyc_q >= 12'(GAP_CYC)) else $error("select gap too short");
    bus_target_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        (DEV_WR || DEV_RD) |-> !(DEV_WR && DEV_RD) && DEV_ADDR == DEV_CTRL_OFS
        && DEV_BE == DEV_PORT_BE) else $error("device access off the port byte");
    start_bit_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        (st_q == ST_SET && phase_q == PH_HDR && idx_q == 4'h0)
        |=> DEV_WR && DEV_WDATA[DI_POS] && DEV_WDATA[CS_POS] ##1 DEV_WR && DEV_WDATA[SK_POS])
        else $error("start bit not one");
    read_sample_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        (st_q == ST_RTAKE && phase_q == PH_DATA) |-> sk_q && cs_q ##2 DEV_WR && !DEV_WDATA[SK_POS])
        else $error("data sampled outside clock high");
    addr_sample_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        (st_q == ST_RREQ && phase_q == PH_ADDR) |-> !sk_q ##2 DEV_RD == 1'b0 && st_q == ST_RTAKE)
        else $error("address sample misplaced");
    end_desel_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        $fell(busy_q) |-> !cs_q && !DEV_WDATA[CS_POS])
        else $error("access ended with select high");
    data_count_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        (fin && (op_q == READ_CMD || op_q == WRITE_CMD))
        |-> rise_q == 6'(HDR_BITS) + 6'(aw_q) + 6'(DATA_BITS)) else $error("wrong clock pulse count");
endmodule

// ===== hw/eeh_tick.sv
`timescale 1ns/1ps
module eeh_tick #(
    parameter int US_CYCLES = eeh_pkg::US_CYCLES
) (
    input wire logic clk,
    input wire logic rstn,
    eeh_tick_if.gen tk
);
    import eeh_pkg::*;
    localparam int CW = $clog2(US_CYCLES);

    if (US_CYCLES < 2) begin : g_bad_rate
        $error("microsecond divider needs at least two cycles");
    end

    logic [CW-1:0] cnt_q;
    wire wrap = (cnt_q == CW'(US_CYCLES - 1));

    // restart on clear so a wait is never shortened by a partial period
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= '0;
            tk.tick <= 1'b0;
        end else begin
            cnt_q <= (tk.clr || wrap) ? '0 : CW'(cnt_q + 1'b1);
            tk.tick <= !tk.clr && wrap;
        end
    end
endmodule

// ===== include/eeh_pkg.sv
package eeh_pkg;
    // ------------------------------------------------------------
    // device side: eeprom access byte inside the control dword
    // ------------------------------------------------------------
    localparam logic [7:0] DEV_CTRL_OFS = 8'h0C;
    localparam logic [7:0] DEV_PORT_OFS = 8'h0E;
    localparam logic [3:0] DEV_PORT_BE = 4'h4;
    localparam int SK_POS = 16;
    localparam int CS_POS = 17;
    localparam int DI_POS = 18;
    localparam int DO_POS = 19;

    // ------------------------------------------------------------
    // own register map
    // ------------------------------------------------------------
    localparam logic [7:0] SW_CTRL_OFS = 8'h00;
    localparam logic [7:0] SW_ADDR_OFS = 8'h04;
    localparam logic [7:0] SW_WDATA_OFS = 8'h08;
    localparam logic [7:0] SW_STAT_OFS = 8'h0C;
    localparam logic [7:0] SW_RDATA_OFS = 8'h10;
    localparam logic [7:0] SW_CFG_OFS = 8'h14;
    localparam int CTRL_GO_POS = 0;
    localparam int CTRL_OP_LSB = 1;
    localparam int STAT_BUSY_POS = 0;
    localparam int STAT_DONE_POS = 1;
    localparam int STAT_NODUMMY_POS = 2;
    localparam int STAT_AW_LSB = 8;

    // ------------------------------------------------------------
    // protocol figures
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_W_RST = 4'h6;
    localparam logic [3:0] ADDR_W_BIG = 4'h8;
    localparam logic [3:0] ADDR_W_MAX = 4'h8;
    localparam logic [3:0] HDR_BITS = 4'h3;
    localparam logic [4:0] DATA_BITS = 5'h10;
    localparam logic [1:0] OPC_READ = 2'h2;
    localparam logic [1:0] OPC_WRITE = 2'h1;
    localparam logic [1:0] OPC_ERASE = 2'h3;
    localparam logic [1:0] OPC_SPECIAL = 2'h0;
    localparam logic [1:0] SUB_ENABLE = 2'h3;
    localparam logic [1:0] SUB_DISABLE = 2'h0;
    localparam logic [1:0] SUB_ERASE_ALL = 2'h2;
    localparam logic [1:0] SUB_WRITE_ALL = 2'h1;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 5000;
    localparam int US_PS = 1000000;
    localparam int US_CYCLES = (US_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [1:0] SK_HIGH_US = 2'h1;
    localparam logic [1:0] SK_LOW_US = 2'h3;
    localparam logic [1:0] CS_GAP_US = 2'h1;
    localparam int SK_HIGH_CYC = int'(SK_HIGH_US) * US_CYCLES;
    localparam int SK_LOW_CYC = int'(SK_LOW_US) * US_CYCLES;
    localparam int CS_GAP_CYC = int'(CS_GAP_US) * US_CYCLES;

    typedef enum logic [2:0] {
        READ_CMD, WRITE_CMD, ERASE_CMD, ERASE_WRITE_ENABLE_CMD,
        ERASE_WRITE_DISABLE_CMD, ERASE_ALL_CMD, WRITE_ALL_CMD, SIZE_PROBE_CMD
    } eeh_op_type;

    typedef enum logic [1:0] {PH_HDR, PH_ADDR, PH_DATA} eeh_phase_type;

    typedef enum {
        ST_IDLE, ST_SEL, ST_SET, ST_HI, ST_LO, ST_WAIT,
        ST_RREQ, ST_RWAIT, ST_RTAKE, ST_ADV, ST_DESEL
    } eeh_state_type;
endpackage

// ===== include/eeh_tick_if.sv
`timescale 1ns/1ps
interface eeh_tick_if;
    logic tick;
    logic clr;
    modport gen(input clr, output tick);
    modport user(output clr, input tick);
endinterface

// ===== verification/eeh_dev_model.sv
`timescale 1ns/1ps
module eeh_dev_model #(
    parameter int US_CYC = 10,
    parameter int AW = 8
) (
    input wire logic CLK_SYS,
    input wire logic RSTN,
    input wire logic [7:0] DEV_ADDR,
    input wire logic [31:0] DEV_WDATA,
    input wire logic [3:0] DEV_BE,
    input wire logic DEV_WR,
    input wire logic DEV_RD,
    output logic [31:0] DEV_RDATA,
    output logic [15:0] VIOL_COUNT
);
    // ------------------------------------------------------------
    // port bits and a behavioural three-wire eeprom
    // ------------------------------------------------------------
    logic sk, cs, di, dout, wen;
    logic [2:0] hdr;
    logic [7:0] adr;
    logic [15:0] word, wsh;
    logic [15:0] mem [0:255];
    int n, k, sk_cnt, per_cnt, gap_cnt;

    // contents are nonvolatile, so device reset leaves them alone
    initial begin
        for (int i = 0; i < 256; i++)
            mem[i] = 16'h0000;
    end

    task automatic fill(input logic [15:0] v);
        for (int i = 0; i < 256; i++)
            mem[i] = v;
    endtask

    task automatic shift_in(input logic b);
        n++;
        k = n - 3 - AW;
        if (n <= 3) hdr = {hdr[1:0], b};
        else if (k <= 0) adr = {adr[6:0], b};
        else if (hdr == 3'b110 && k <= 16) dout = word[16 - k];
        else wsh = {wsh[14:0], b};
        if (k == 0) begin
            dout = 1'b0;
            word = mem[adr];
            if (hdr == 3'b111 && wen) mem[adr] = 16'hFFFF;
            if (hdr == 3'b100 && adr[AW-1 -: 2] == 2'b11) wen = 1'b1;
            if (hdr == 3'b100 && adr[AW-1 -: 2] == 2'b00) wen = 1'b0;
            if (hdr == 3'b100 && adr[AW-1 -: 2] == 2'b10 && wen) fill(16'hFFFF);
        end
        if (k == 16 && wen && hdr == 3'b101) mem[adr] = wsh;
        if (k == 16 && wen && hdr == 3'b100 && adr[AW-1 -: 2] == 2'b01) fill(wsh);
    endtask

    always @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            {sk, cs, di, wen} = 4'h0;
            dout = 1'b1;
            n = 0;
            sk_cnt = 1000;
            per_cnt = 1000;
            gap_cnt = 1000;
            VIOL_COUNT = 16'h0000;
            DEV_RDATA <= 32'h00000000;
        end else begin
            sk_cnt++;
            per_cnt++;
            gap_cnt++;
            // an unanswered bus flips every cycle so a late sample shows
            // non-blocking, so the host never races this edge when it samples
            if (DEV_RD) DEV_RDATA <= {12'h000, dout, di, cs, sk, 16'h0000};
            else DEV_RDATA <= ~DEV_RDATA;
            if (DEV_WR && DEV_RD) VIOL_COUNT++;
            if (DEV_WR) begin
                if (DEV_ADDR !== 8'h0C || DEV_BE !== 4'h4) VIOL_COUNT++;
                if (DEV_WDATA[16] != sk) begin
                    if (sk ? sk_cnt < US_CYC : sk_cnt < 3 * US_CYC) VIOL_COUNT++;
                    if (!sk && per_cnt < 4 * US_CYC) VIOL_COUNT++;
                    if (!sk) per_cnt = 0;
                    sk_cnt = 0;
                end
                if (DEV_WDATA[17] && !cs && gap_cnt < US_CYC) VIOL_COUNT++;
                if (!DEV_WDATA[17] && cs) gap_cnt = 0;
                if (DEV_WDATA[16] && !sk && DEV_WDATA[17]) shift_in(DEV_WDATA[18]);
                sk = DEV_WDATA[16];
                cs = DEV_WDATA[17];
                di = DEV_WDATA[18];
                // bit 19 is never taken from a write
                if (!cs) begin
                    n = 0;
                    dout = 1'b1;
                end
            end
        end
    end
endmodule

// ===== verification/eeh_host_tb_top.sv
`timescale 1ns/1ps
module eeh_host_tb_top;
    import eeh_pkg::*;
    // ------------------------------------------------------------
    // clock, reset and wiring
    // ------------------------------------------------------------
    localparam int SIM_PS = 100000;
    localparam int US_SIM = (US_PS + SIM_PS - 1) / SIM_PS;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] sw_addr = 8'h00;
    logic [31:0] sw_wdata = 32'h00000000;
    logic sw_wr = 1'b0;
    logic sw_rd = 1'b0;
    logic [31:0] sw_rdata, dev_wdata, dev_rdata, rd;
    logic [7:0] dev_addr;
    logic [3:0] dev_be;
    logic dev_wr, dev_rd;
    logic [15:0] viol;
    int err_count = 0;
    int n_tests = 0;

    always #2.5 clk_sys = ~clk_sys;

    // a long clock period shortens every microsecond wait
    eeh_host #(.CLK_PERIOD_PS(SIM_PS)) eeh_host_inst (.CLK_SYS(clk_sys), .RSTN(rstn),
        .SW_ADDR(sw_addr), .SW_WDATA(sw_wdata), .SW_WR(sw_wr), .SW_RD(sw_rd),
        .SW_RDATA(sw_rdata), .DEV_ADDR(dev_addr), .DEV_WDATA(dev_wdata), .DEV_BE(dev_be),
        .DEV_WR(dev_wr), .DEV_RD(dev_rd), .DEV_RDATA(dev_rdata));
    eeh_dev_model #(.US_CYC(US_SIM), .AW(8)) eeh_dev_model_inst (.CLK_SYS(clk_sys),
        .RSTN(rstn), .DEV_ADDR(dev_addr), .DEV_WDATA(dev_wdata), .DEV_BE(dev_be),
        .DEV_WR(dev_wr), .DEV_RD(dev_rd), .DEV_RDATA(dev_rdata), .VIOL_COUNT(viol));

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic end_of_test;
        if (err_count == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic sw_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        sw_wr <= 1'b1;
        sw_addr <= a;
        sw_wdata <= d;
        @(posedge clk_sys);
        sw_wr <= 1'b0;
    endtask

    task automatic sw_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        sw_rd <= 1'b1;
        sw_addr <= a;
        @(posedge clk_sys);
        sw_rd <= 1'b0;
        #1 d = sw_rdata;
    endtask

    // polls for done with busy low; done is cleared by go, so no stale pass
    task automatic run_op(input logic [2:0] op, input logic [7:0] a, input logic [15:0] d);
        int i;
        sw_write(SW_ADDR_OFS, {24'h000000, a});
        sw_write(SW_WDATA_OFS, {16'h0000, d});
        sw_write(SW_CTRL_OFS, {28'h0000000, op, 1'b1});
        rd = 32'h00000000;
        for (i = 0; i < 2000 && !(rd[STAT_DONE_POS] === 1'b1 && rd[STAT_BUSY_POS] === 1'b0); i++)
            sw_read(SW_STAT_OFS, rd);
        if (i == 2000) begin
            err_count++;
            end_of_test();
        end
    endtask

    task automatic check_word(input logic [7:0] a, input logic [15:0] exp);
        run_op(3'h0, a, 16'h0000);
        sw_read(SW_RDATA_OFS, rd);
        cmp32(rd, {16'h0000, exp});
    endtask

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        repeat (5) @(posedge clk_sys);
        rstn <= 1'b1;
        sw_read(SW_STAT_OFS, rd);
        cmp32(rd, {20'h00000, ADDR_W_RST, 8'h00});
        sw_read(SW_CFG_OFS, rd);
        cmp32(rd, {28'h0000000, ADDR_W_RST});
        sw_read(8'h40, rd);
        cmp32(rd, 32'h00000000);
        run_op(3'h7, 8'h00, 16'h0000);
        sw_read(SW_STAT_OFS, rd);
        cmp32(rd, 32'h00000802);
        sw_read(SW_CTRL_OFS, rd);
        cmp32(rd, 32'h0000000E);
        run_op(3'h3, 8'h00, 16'h0000);
        run_op(3'h1, 8'h5A, 16'hA5C3);
        check_word(8'h5A, 16'hA5C3);
        run_op(3'h2, 8'h5A, 16'h0000);
        check_word(8'h5A, 16'hFFFF);
        run_op(3'h6, 8'h00, 16'h1234);
        check_word(8'h03, 16'h1234);
        run_op(3'h5, 8'h00, 16'h0000);
        check_word(8'hC7, 16'hFFFF);
        run_op(3'h4, 8'h00, 16'h0000);
        run_op(3'h1, 8'h05, 16'h0000);
        check_word(8'h05, 16'hFFFF);
        // a width shorter than the part leaves no dummy zero at its end
        sw_write(SW_CFG_OFS, 32'h00000006);
        run_op(3'h0, 8'h01, 16'h0000);
        sw_read(SW_STAT_OFS, rd);
        cmp32(rd, 32'h00000606);
        cmp32(dev_wdata, 32'h00000000);
        cmp32({16'h0000, viol}, 32'h00000000);
        end_of_test();
    end

    initial begin
        #400000;
        err_count++;
        end_of_test();
    end
endmodule
